// [hdl/sdram_port_pkg.sv]
// sdram_port_pkg: constants and types shared by the external-port sdram/flyby block.
// assumes a single 10 MHz system clock; no software-visible registers.
package sdram_port_pkg;
   localparam int ADDR_W = 32;
   localparam int SPACE_HI = 31;
   localparam int SPACE_LO = 26;
   localparam logic [5:0] SDRAM_SPACE = 6'h01;
   localparam int DMA_CH = 4;
   localparam int CLK_MHZ = 10;
   // sdram command encodings {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_MRS = 3'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ACT = 3'h1,
      ST_COL = 3'h3,
      ST_PRE = 3'h2,
      ST_SREF = 3'h6,
      ST_GRANT = 3'h7
   } port_state_e;
endpackage : sdram_port_pkg

// [hdl/sdram_port.sv]
// sdram_port: sdram command/strobe/mask generation, clock-enable and bus handover,
// and flyby dma strobes for external i/o devices.
// assumes a core-side request port on the same clock and async dma request pins.
//
// Behaviour
// - space select on sdram command cycles
// - only bus master drives space select
// - ras low marks row, else command
// - cas low marks column, else command
// - write strobe low write, high read
// - low mask only with cas, inactive reads
// - mask low word on odd 64-bit writes
// - mask high word even or 32-bit writes
// - separate address bit ten pin
// - clock gate low for self-refresh/suspend
// - handover keeps clock gate state; slaves release
// - flyby channel asserts strobe per transfer
// - i/o output enable only during flyby
// - four async requests start programmed channel
// - ignore requests on uninitialised channels
// - self-refresh before host grant; tristate in the grant cycle
`timescale 1ns/1ns
`default_nettype none
module sdram_port
   import sdram_port_pkg::*;
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_is_master, // this device owns the cluster bus
   input wire logic i_bus64, // memory configured as 64-bit bus
   input wire logic i_req, // core access request
   input wire logic i_req_wr, // request is a write
   input wire logic [sdram_port_pkg::ADDR_W-1:0] i_req_addr, // word address
   input wire logic i_refresh, // issue auto refresh
   input wire logic i_suspend, // hold sdram in suspend
   input wire logic i_host_request, // host bus request, pin
   input wire logic [sdram_port_pkg::DMA_CH-1:0] i_external_dma_request_n, // async dma requests
   input wire logic [sdram_port_pkg::DMA_CH-1:0] i_ch_init, // channel initialised
   input wire logic [sdram_port_pkg::DMA_CH-1:0] i_ch_flyby, // channel in flyby mode
   output logic o_req_ack, // request accepted (combinational)
   output logic [sdram_port_pkg::DMA_CH-1:0] o_dma_start, // channel service pulse
   output logic o_sdram_space_select_n, // space select, active low
   output logic o_sdram_space_select_oe, // drive enable
   output logic o_ras_n, // row strobe
   output logic o_cas_n, // column strobe
   output logic o_sdram_write_strobe_n, // write enable
   output logic o_low_word_mask, // low data mask
   output logic o_high_word_mask, // high data mask
   output logic o_sdram_addr_bit_ten, // address bit 10
   output logic o_sdram_clock_gate, // sdram clock enable
   output logic o_sdram_clock_gate_oe, // clock gate drive enable
   output logic o_ctl_oe, // strobes/masks drive enable
   output logic o_flyby_n, // flyby strobe, active low
   output logic o_io_device_output_enable_n, // i/o device output enable
   output logic o_host_grant_n, // host grant, active low
   output logic o_host_grant_oe // host grant drive enable
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      port_state_e st;
      logic [2:0] cmd;
      logic sel;
      logic low_word_mask;
      logic high_word_mask;
      logic a10;
      logic cke;
      logic wr;
      logic odd;
      logic flyby;
      // two-stage synchronisers and edge history for the request pins
      logic [DMA_CH-1:0] dreq_m;
      logic [DMA_CH-1:0] dreq_s;
      logic [DMA_CH-1:0] dreq_d;
      logic [DMA_CH-1:0] start;
      // host request pin, synchronised the same way
      logic hreq_m;
      logic hreq_s;
      logic grant;
   } state_s;

   state_s cur_r;
   state_s cur_nxt;
   logic hit;
   logic [DMA_CH-1:0] fly_req;

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   logic idle_free;
   assign hit = i_req_addr[SPACE_HI:SPACE_LO] == SDRAM_SPACE;
   // an access is only taken when it can be issued at once, so a refused
   // request simply waits; suspend blocks it since the clock gate is low
   assign idle_free = cur_r.st == ST_IDLE && !cur_r.hreq_s && !i_refresh && !i_suspend;
   assign o_req_ack = i_req && hit && idle_free;
   // flyby only when some initialised flyby channel requests
   // limitation: a start pulse that meets no access is not kept, the device must ask again
   assign fly_req = cur_r.start & i_ch_flyby;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      cur_nxt = cur_r;
      // ---------------------------------------------------------------
      // dma and host request capture
      // ---------------------------------------------------------------
      // first stage feeds only the second stage
      cur_nxt.dreq_m = ~i_external_dma_request_n;
      cur_nxt.dreq_s = cur_r.dreq_m;
      cur_nxt.dreq_d = cur_r.dreq_s;
      // rising edge of a request, masked by channel init
      cur_nxt.start = cur_r.dreq_s & ~cur_r.dreq_d & i_ch_init;
      cur_nxt.hreq_m = i_host_request;
      cur_nxt.hreq_s = cur_r.hreq_m;
      // ---------------------------------------------------------------
      // command sequencer
      // ---------------------------------------------------------------
      // every command lasts one cycle; nop is the resting code
      cur_nxt.cmd = CMD_NOP;
      cur_nxt.sel = 1'b0;
      cur_nxt.low_word_mask = 1'b0;
      cur_nxt.high_word_mask = 1'b0;
      cur_nxt.a10 = 1'b0;
      cur_nxt.flyby = 1'b0;
      unique case (cur_r.st)
         ST_IDLE: begin
            cur_nxt.cke = !i_suspend;
            if (cur_r.hreq_s) begin
               // enter self-refresh before handing the bus over
               cur_nxt.cmd = CMD_REF;
               cur_nxt.sel = 1'b1;
               cur_nxt.cke = 1'b0;
               cur_nxt.st = ST_SREF;
            end else if (i_refresh) begin
               // precharge all banks first, then auto refresh on the next cycle
               cur_nxt.cmd = CMD_PRE;
               cur_nxt.a10 = 1'b1;
               cur_nxt.sel = 1'b1;
               cur_nxt.st = ST_PRE;
            end else if (o_req_ack && !i_suspend) begin
               cur_nxt.cmd = CMD_ACT;
               cur_nxt.sel = 1'b1;
               cur_nxt.a10 = i_req_addr[10];
               cur_nxt.wr = i_req_wr;
               cur_nxt.odd = i_req_addr[0];
               cur_nxt.flyby = |fly_req;
               cur_nxt.st = ST_ACT;
            end
         end
         ST_ACT: begin
            cur_nxt.cmd = cur_r.wr ? CMD_WR : CMD_RD;
            cur_nxt.sel = 1'b1;
            cur_nxt.a10 = 1'b1; // auto precharge
            cur_nxt.flyby = cur_r.flyby;
            // masks ride with the column command so the memory sees them with cas
            cur_nxt.low_word_mask = cur_r.wr && i_bus64 && cur_r.odd;
            cur_nxt.high_word_mask = cur_r.wr && (!i_bus64 || !cur_r.odd);
            cur_nxt.st = ST_COL;
         end
         ST_COL: cur_nxt.st = ST_IDLE;
         ST_PRE: begin
            cur_nxt.cmd = CMD_REF;
            cur_nxt.sel = 1'b1;
            cur_nxt.st = ST_IDLE;
         end
         ST_SREF: begin
            // self-refresh entry has gone out; the host gets the bus one cycle later
            cur_nxt.grant = 1'b1;
            cur_nxt.st = ST_GRANT;
         end
         ST_GRANT: begin
            // grant held until host withdraws its request
            if (!cur_r.hreq_s) begin
               cur_nxt.grant = 1'b0;
               // the memory leaves self-refresh only once the host has let go
               cur_nxt.cke = 1'b1;
               cur_nxt.st = ST_IDLE;
            end
         end
         default: cur_nxt.st = ST_IDLE;
      endcase
      if (!i_rst_n) begin
         // synchronous reset overrides every branch above
         cur_nxt = '0;
         cur_nxt.st = ST_IDLE;
         cur_nxt.cmd = CMD_NOP;
         cur_nxt.cke = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      cur_r <= cur_nxt;
   end

   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   logic drive;
   // only the master drives, and never while the host holds the bus
   assign drive = i_is_master && cur_r.st != ST_GRANT;
   // a pin with its enable low still shows its register value here; the pad ring floats it
   assign o_dma_start = cur_r.start;
   assign o_sdram_space_select_n = !cur_r.sel;
   assign o_sdram_space_select_oe = drive;
   assign o_ras_n = cur_r.cmd[2];
   assign o_cas_n = cur_r.cmd[1];
   assign o_sdram_write_strobe_n = cur_r.cmd[0];
   assign o_low_word_mask = cur_r.low_word_mask;
   assign o_high_word_mask = cur_r.high_word_mask;
   assign o_sdram_addr_bit_ten = cur_r.a10;
   assign o_sdram_clock_gate = cur_r.cke;
   // master keeps the level (low in self-refresh) across handover
   assign o_sdram_clock_gate_oe = i_is_master;
   assign o_ctl_oe = drive;
   assign o_flyby_n = !cur_r.flyby;
   // the i/o device sources the data only when memory is written; on a
   // flyby read the memory drives the bus and the device must stay off
   assign o_io_device_output_enable_n = !(cur_r.flyby && cur_r.wr);
   assign o_host_grant_n = !cur_r.grant;
   assign o_host_grant_oe = i_is_master;
endmodule : sdram_port
`default_nettype wire

// [verification/sdram_port_checker.sv]
// sdram_port_checker: port-level properties of the sdram/flyby block.
// assumes it is bound onto sdram_port; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module sdram_port_checker
   import sdram_port_pkg::*;
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_is_master, // bus master
   input wire logic i_bus64, // 64-bit bus
   input wire logic i_req_wr, // request is a write
   input wire logic o_req_ack, // request taken
   input wire logic [sdram_port_pkg::ADDR_W-1:0] i_req_addr, // request address
   input wire logic o_sdram_space_select_n, // space select
   input wire logic o_sdram_space_select_oe, // select drive enable
   input wire logic o_ras_n, // row strobe
   input wire logic o_cas_n, // column strobe
   input wire logic o_sdram_write_strobe_n, // write enable
   input wire logic o_low_word_mask, // low mask
   input wire logic o_high_word_mask, // high mask
   input wire logic o_sdram_addr_bit_ten, // address bit ten
   input wire logic o_sdram_clock_gate, // clock gate
   input wire logic o_ctl_oe, // strobe drive enable
   input wire logic o_flyby_n, // flyby strobe
   input wire logic o_io_device_output_enable_n, // i/o output enable
   input wire logic o_host_grant_n // host grant
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // ----
   // command and mask timing, bus drive, grant and flyby enable
   // ----
   act_follows_a: assert property (o_req_ack |=> !o_sdram_space_select_n && !o_ras_n)
      else $error("row command missing");
   row_bit_a: assert property (o_req_ack |=> o_sdram_addr_bit_ten == $past(i_req_addr[10]))
      else $error("row bit ten wrong");
   col_cmd_a: assert property (o_req_ack |-> ##2 !o_cas_n && o_sdram_write_strobe_n == !$past(i_req_wr, 2))
      else $error("column command wrong");
   low_mask_a: assert property (
      o_req_ack && i_req_wr && i_bus64 && i_req_addr[0] |-> ##2 o_low_word_mask && !o_high_word_mask)
      else $error("low mask wrong");
   high_mask_a: assert property (
      o_req_ack && i_req_wr && !(i_bus64 && i_req_addr[0]) |-> ##2 o_high_word_mask && !o_low_word_mask)
      else $error("high mask wrong");
   read_mask_a: assert property (
      o_ras_n && !o_cas_n && o_sdram_write_strobe_n |-> !o_low_word_mask && !o_high_word_mask)
      else $error("mask on read");
   mask_cas_a: assert property (o_low_word_mask || o_high_word_mask |-> !o_cas_n && !o_sdram_write_strobe_n)
      else $error("mask outside write");
   sel_master_a: assert property (
      !(i_is_master && o_host_grant_n) |-> !o_sdram_space_select_oe && !o_ctl_oe)
      else $error("select driven without the bus");
   grant_sref_a: assert property (!o_host_grant_n |-> !o_sdram_clock_gate)
      else $error("grant without self-refresh");
   io_device_output_enable_flyby_a: assert property (!o_io_device_output_enable_n |-> !o_flyby_n)
      else $error("enable outside flyby");
endmodule : sdram_port_checker
`default_nettype wire

// [verification/io_dev_model.sv]
// io_dev_model: external i/o device; raises dma requests, steps its data each clock the strobe is low.
// assumes the system clock; request lines idle high as with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module io_dev_model (
   input wire logic i_clk, // system clock
   input wire logic [3:0] i_go, // bench asks for service
   input wire logic i_flyby_n, // flyby strobe
   output logic [3:0] o_req_n = 4'hf, // dma request lines
   output logic [7:0] o_word = 8'h00 // data offered
);
   always @(posedge i_clk) begin
      o_req_n <= ~i_go;
      if (!i_flyby_n) o_word <= o_word + 8'h01;
   end
endmodule : io_dev_model
`default_nettype wire

// [verification/tb.sv]
// tb: self-checking bench for sdram_port with an i/o device model.
// assumes a 100 ns clock; checker bound below.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sdram_port_pkg::*;
   logic i_clk_sys = 0, i_rst_n = 0, i_is_master = 1, i_bus64 = 0, i_req = 0, i_req_wr = 0;
   logic i_refresh = 0, i_suspend = 0, i_host_request = 0;
   logic [31:0] i_req_addr = '0, a;
   logic [3:0] i_external_dma_request_n, i_ch_init = 4'h5, i_ch_flyby = 4'h1, o_dma_start, go = 4'h0, seen;
   logic [7:0] word, w0;
   logic o_req_ack, o_sdram_space_select_n, o_sdram_space_select_oe, o_ras_n, o_cas_n;
   logic o_sdram_write_strobe_n, o_low_word_mask, o_high_word_mask, o_sdram_addr_bit_ten;
   logic o_sdram_clock_gate, o_sdram_clock_gate_oe, o_ctl_oe, o_flyby_n;
   logic o_io_device_output_enable_n, o_host_grant_n, o_host_grant_oe;
   int n_fail = 0, n_compared = 0, k;
   sdram_port dut (.*);
   io_dev_model dev (.i_clk(i_clk_sys), .i_go(go), .i_flyby_n(o_flyby_n), .o_req_n(i_external_dma_request_n),
      .o_word(word));
   always #50 i_clk_sys = ~i_clk_sys;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // ----
   // one access; refused ones leave the ack low
   // ----
   task automatic acc(input logic wr, input logic [31:0] ad, input logic b64, input logic ok);
      int i;
      i_req = 1;
      i_req_wr = wr;
      i_req_addr = ad;
      i_bus64 = b64;
      for (i = 0; i < 6; i++) begin
         #5;
         if (o_req_ack === 1'b1) break;
         @(posedge i_clk_sys) #5;
      end
      chk(o_req_ack, ok);
      @(posedge i_clk_sys) #10 i_req = 0;
      if (ok) begin
         chk({o_sdram_space_select_n, o_ras_n, o_cas_n, o_sdram_addr_bit_ten}, {3'h1, ad[10]});
         @(posedge i_clk_sys) #10;
         chk({o_ras_n, o_cas_n, o_sdram_write_strobe_n, o_low_word_mask, o_high_word_mask},
            {2'h2, !wr, wr & b64 & ad[0], wr & !(b64 & ad[0])});
      end else begin
         // let an edge pass so a following call never re-raises the request in this time step
         @(posedge i_clk_sys) #10;
      end
   endtask : acc
   initial begin
      #3000000 n_fail++;
      conclude();
   end
   initial begin
      void'($urandom(32'hcb6db9d4));
      repeat (3) @(posedge i_clk_sys);
      #10 chk({o_sdram_space_select_n, o_ras_n, o_sdram_clock_gate, o_host_grant_n}, 4'hf);
      i_rst_n = 1;
      for (k = 0; k < 24; k++) begin
         a = {$urandom_range(0, 3) != 0 ? SDRAM_SPACE : 6'h02, 26'($urandom)};
         acc(1'($urandom), a, 1'($urandom), a[31:26] == SDRAM_SPACE);
      end
      acc(1'b1, 32'h0400_0401, 1'b1, 1'b1);
      acc(1'b0, 32'h0400_0001, 1'b1, 1'b1);
      i_suspend = 1;
      repeat (3) @(posedge i_clk_sys);
      #10 chk(o_sdram_clock_gate, 1'b0);
      acc(1'b1, 32'h0400_0000, 1'b0, 1'b0);
      i_suspend = 0;
      i_refresh = 1;
      for (k = 0; k < 8 && o_ras_n !== 1'b0; k++) @(posedge i_clk_sys) #10;
      i_refresh = 0;
      chk({o_ras_n, o_cas_n, o_sdram_write_strobe_n, o_sdram_addr_bit_ten}, 4'h5);
      @(posedge i_clk_sys) #10 chk({o_ras_n, o_cas_n, o_sdram_write_strobe_n}, 3'h1);
      seen = 0;
      go = 4'hf;
      @(posedge i_clk_sys) #10 go = 0;
      repeat (6) @(posedge i_clk_sys) #10 seen |= o_dma_start;
      chk(seen, i_ch_init);
      // flyby: a core write issued while the channel 0 start pulse stands
      w0 = word;
      go = 4'h1;
      @(posedge i_clk_sys) #10 go = 4'h0;
      for (k = 0; k < 8 && o_dma_start[0] !== 1'b1; k++) @(posedge i_clk_sys) #10;
      acc(1'b1, 32'h0400_0002, 1'b1, 1'b1);
      chk({o_flyby_n, o_io_device_output_enable_n}, 2'h0);
      @(posedge i_clk_sys) #10 chk(word - w0, 8'h02);
      i_host_request = 1;
      for (k = 0; k < 12 && o_host_grant_n !== 1'b0; k++) @(posedge i_clk_sys) #10;
      chk({o_host_grant_n, o_sdram_clock_gate, o_ctl_oe}, 3'h0);
      i_host_request = 0;
      for (k = 0; k < 12 && o_sdram_clock_gate !== 1'b1; k++) @(posedge i_clk_sys) #10;
      chk({o_host_grant_n, o_sdram_clock_gate}, 2'h3);
      i_is_master = 0;
      #5 chk({o_sdram_space_select_oe, o_sdram_clock_gate_oe, o_host_grant_oe}, 3'h0);
      conclude();
   end
endmodule : tb
bind sdram_port sdram_port_checker chk_u (.*);
`default_nettype wire
